// ==== vuofr_pkg.sv ====
// package for the vector unit operand and flow block
package vuofr_pkg;
   localparam int IP_W        = 32;                // instruction pointer width
   localparam int CHANNELS    = 16;                // execution channels
   localparam int IMM_W       = 32;                // packed immediate width
   localparam int NIB_LANES   = 8;                 // nibble lanes per immediate
   localparam int NIB_W       = 4;                 // nibble lane width
   localparam int RF_LANES    = 4;                 // restricted float lanes
   localparam int RF_W        = 8;                 // restricted float lane width
   localparam int WORD_W      = 16;                // word width
   localparam int NATIVE_W    = 128;               // native instruction width
   localparam int COMPACT_W   = 64;                // compact instruction width
   localparam int SWZ_GROUP   = 4;                 // swizzle group size
   localparam int WIDTH_W     = 3;                 // exec width code bits
   localparam int RF_ADDR_W   = 12;                // register file address width

   // immediate kinds delivered with an instruction
   typedef enum logic [1:0] {
      VUOFR_IMM_NONE,
      VUOFR_IMM_UNIB,
      VUOFR_IMM_SNIB,
      VUOFR_IMM_RFLT
   } vuofr_imm_kind_t;

   // decoded instruction as it enters the block
   typedef struct packed {
      logic [IP_W-1:0]      ip;          // address of this instruction
      logic                 is_send;     // message send
      logic                 end_flag;    // end-of-thread flag on a send
      logic                 except;      // enabled exception raised
      logic                 quad_mode;   // sixteen aligned access mode
      logic [7:0]           swizzle;     // four 2-bit selectors
      logic [WIDTH_W-1:0]   exec_width;  // log2 of element count
      logic                 null_dst;    // destination is null
      logic                 acc_wr;      // implicit accumulator update
      logic                 flag_wr;     // implicit flag update
      logic                 mem_operand; // operand names memory (illegal)
      logic                 compact;     // 64-bit compact encoding
      vuofr_imm_kind_t      imm_kind;    // immediate vector kind
      logic [IMM_W-1:0]     imm;         // raw immediate
   } vuofr_instr_t;
endpackage : vuofr_pkg

// ==== vuofr_lane.sv ====
// per-channel eligibility and operand swizzle for one channel
`timescale 1ns/1ns
module vuofr_lane #(
   parameter int IP_W = 32,
   parameter int IDX  = 0
) (
   input  wire logic            single_flow_mode,
   input  wire logic [IP_W-1:0] channel_instr_pointer,
   input  wire logic [IP_W-1:0] thread_instr_pointer,
   input  wire logic            chan_mask,
   input  wire logic            width_en,
   input  wire logic            quad_mode,
   input  wire logic [7:0]      swizzle,
   input  wire logic [15:0]     src_in,
   output logic                 eligible,
   output logic [3:0]           src_sel
);
   logic ptr_match;  // own pointer matches the thread pointer
   logic [1:0] pick; // selector for this lane within its group
   always_comb begin
      ptr_match = (channel_instr_pointer == thread_instr_pointer);
      // shared pointer in single flow, own pointer otherwise
      eligible  = chan_mask & width_en & (single_flow_mode | ptr_match);
      pick      = swizzle[2*(IDX%4) +: 2];
      // modulo four selection inside the aligned group of four
      src_sel   = quad_mode ? {2'(IDX/4 % 4), pick} : 4'(IDX % 16);
   end
   logic unused_src;
   assign unused_src = ^src_in;
endmodule : vuofr_lane

// ==== vuofr_core.sv ====
// thread flow, operand typing and lane control of the vector unit
//
// Behaviour
// - flow bit picks shared or per-channel pointers
// - per-channel pointer must match thread pointer
// - aligned mode swizzles sources modulo four
// - enabled exception jumps to global handler
// - handler starts at handler entry pointer
// - thread ends only on send with flag
// - exec width sets parallel element count
// - operands touch register file, never memory
// - word is sixteen bits, bit zero lowest
// - unsigned nibble immediate gives eight lanes
// - signed nibble immediate gives eight lanes
// - real immediate gives four byte lanes
// - byte types span eight bits
// - halfword types span sixteen bits
// - native format 128 bits, compact 64
// - null destination discards, implicit updates remain
`timescale 1ns/1ns
module vuofr_core
   import vuofr_pkg::*;
#(
   parameter int CH = vuofr_pkg::CHANNELS
) (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire logic                          dispatch,
   input  wire logic [vuofr_pkg::IP_W-1:0]    dispatch_ip,
   input  wire logic [vuofr_pkg::IP_W-1:0]    handler_entry_pointer,
   input  wire logic                          single_flow_mode,
   input  wire logic [CH-1:0]                 chan_mask,
   input  wire logic [CH*vuofr_pkg::IP_W-1:0] channel_instr_pointer,
   input  wire logic                          instr_valid,
   input  wire vuofr_pkg::vuofr_instr_t       instr,
   input  wire logic [CH*16-1:0]              src_data,
   output logic                               thread_active,
   output logic [vuofr_pkg::IP_W-1:0]         thread_instr_pointer,
   output logic                               thread_done,
   output logic                               handler_taken,
   output logic [CH-1:0]                      exec_lanes,
   output logic [CH*4-1:0]                    swizzle_sel,
   output logic [CH*16-1:0]                   src_words,
   output logic [4*vuofr_pkg::IMM_W-1:0]      imm_lanes,
   output logic                               dst_write,
   output logic                               acc_write,
   output logic                               flag_write,
   output logic                               instr_fault
);
   import vuofr_pkg::*;

   typedef enum logic [1:0] {VUOFR_IDLE, VUOFR_RUN} vuofr_state_t;

   vuofr_state_t             state_q, state_d;   // thread life cycle
   logic [IP_W-1:0]          ip_q, ip_d;         // thread pointer
   logic                     done_q, done_d;     // end pulse
   logic                     hnd_q, hnd_d;       // handler entry pulse
   logic [CH-1:0]            lanes_q, lanes_d;   // enabled lanes
   logic [CH*4-1:0]          sel_q, sel_d;       // swizzle selectors
   logic [CH*16-1:0]         words_q, words_d;   // swizzled sources
   logic [4*IMM_W-1:0]       imm_q, imm_d;       // expanded immediate
   logic                     dst_q, dst_d;       // destination write
   logic                     acc_q, acc_d;       // accumulator write
   logic                     flg_q, flg_d;       // flag write
   logic                     flt_q, flt_d;       // illegal instruction
   logic                     active_q, active_d; // running flag for the port
   logic [CH-1:0]            elig;               // per-lane eligibility
   logic [CH*4-1:0]          sel_c;              // per-lane selector
   logic [CH-1:0]            width_en;           // inside exec width

   // element count from the width code, saturated at channel count
   function automatic logic [CH-1:0] width_mask(input logic [WIDTH_W-1:0] w);
      logic [CH-1:0] m;
      m = '0;
      for (int i = 0; i < CH; i++) begin
         m[i] = (i < (1 << w));
      end
      return m;
   endfunction : width_mask

   // one nibble lane as an 8-bit element, signed or not
   function automatic logic [7:0] nib_ext(input logic [NIB_W-1:0] n, input logic sgn);
      return sgn ? {{4{n[3]}}, n} : {4'h0, n};
   endfunction : nib_ext

   assign width_en = width_mask(instr.exec_width);

   // one lane checker per channel
   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : gen_lane
         vuofr_lane #(.IP_W(IP_W), .IDX(g)) u_lane (
            .single_flow_mode      (single_flow_mode),
            .channel_instr_pointer (channel_instr_pointer[g*IP_W +: IP_W]),
            .thread_instr_pointer  (ip_q),
            .chan_mask             (chan_mask[g]),
            .width_en              (width_en[g]),
            .quad_mode             (instr.quad_mode),
            .swizzle               (instr.swizzle),
            .src_in                (src_data[g*16 +: 16]),
            .eligible              (elig[g]),
            .src_sel               (sel_c[g*4 +: 4])
         );
      end
   endgenerate

   // next state of the thread and of the lane outputs
   always_comb begin
      state_d = state_q;
      ip_d    = ip_q;
      done_d  = 1'b0;
      hnd_d   = 1'b0;
      lanes_d = lanes_q;
      sel_d   = sel_q;
      words_d = words_q;
      imm_d   = imm_q;
      dst_d   = 1'b0;
      acc_d   = 1'b0;
      flg_d   = 1'b0;
      flt_d   = 1'b0;
      case (state_q)
         VUOFR_IDLE: begin
            lanes_d = '0;
            // first instruction comes from the dispatcher
            if (dispatch) begin
               state_d = VUOFR_RUN;
               ip_d    = dispatch_ip;
            end
         end
         VUOFR_RUN: begin
            if (instr_valid) begin
               // memory operands are refused, nothing is written
               if (instr.mem_operand) begin
                  flt_d   = 1'b1;
                  lanes_d = '0;
               end else begin
                  lanes_d = elig;
                  sel_d   = sel_c;
                  // gather each lane's source word by its selector
                  for (int i = 0; i < CH; i++) begin
                     words_d[i*WORD_W +: WORD_W] =
                        src_data[sel_c[i*4 +: 4]*WORD_W +: WORD_W];
                  end
                  // null destination drops results, implicit updates stay
                  dst_d = ~instr.null_dst & (|elig);
                  acc_d = instr.acc_wr & (|elig);
                  flg_d = instr.flag_wr & (|elig);
               end
               // immediate expansion, lane zero in the low bits
               imm_d = '0;
               case (instr.imm_kind)
                  VUOFR_IMM_UNIB, VUOFR_IMM_SNIB: begin
                     for (int l = 0; l < NIB_LANES; l++) begin
                        imm_d[l*16 +: 16] = {8'h00, nib_ext(instr.imm[l*NIB_W +: NIB_W],
                           instr.imm_kind == VUOFR_IMM_SNIB)};
                        if (instr.imm_kind == VUOFR_IMM_SNIB && instr.imm[l*NIB_W+3])
                           imm_d[l*16+8 +: 8] = 8'hFF;
                     end
                  end
                  VUOFR_IMM_RFLT: begin
                     for (int l = 0; l < RF_LANES; l++) begin
                        imm_d[l*IMM_W +: IMM_W] =
                           {24'h00_0000, instr.imm[l*RF_W +: RF_W]};
                     end
                  end
                  default: imm_d = '0;
               endcase
               // flow: exception, end of thread, or next instruction
               if (instr.except) begin
                  ip_d  = handler_entry_pointer;
                  hnd_d = 1'b1;
               end else if (instr.is_send && instr.end_flag) begin
                  state_d = VUOFR_IDLE;
                  done_d  = 1'b1;
               end else begin
                  // compact instructions are 8 bytes, native 16
                  ip_d = ip_q
                     + (instr.compact ? IP_W'(COMPACT_W/8) : IP_W'(NATIVE_W/8));
               end
            end
         end
         default: state_d = VUOFR_IDLE;
      endcase
      // running flag kept in its own flop so the port needs no decode
      active_d = (state_d == VUOFR_RUN);
   end

   // register all state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= VUOFR_IDLE;
         ip_q    <= '0;
         done_q  <= 1'b0;
         hnd_q   <= 1'b0;
         lanes_q <= '0;
         sel_q   <= '0;
         words_q <= '0;
         imm_q   <= '0;
         dst_q   <= 1'b0;
         acc_q   <= 1'b0;
         flg_q   <= 1'b0;
         flt_q   <= 1'b0;
         active_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ip_q    <= ip_d;
         done_q  <= done_d;
         hnd_q   <= hnd_d;
         lanes_q <= lanes_d;
         sel_q   <= sel_d;
         words_q <= words_d;
         imm_q   <= imm_d;
         dst_q   <= dst_d;
         acc_q   <= acc_d;
         flg_q   <= flg_d;
         flt_q   <= flt_d;
         active_q <= active_d;
      end
   end

   assign thread_active        = active_q;
   assign thread_instr_pointer = ip_q;
   assign thread_done          = done_q;
   assign handler_taken        = hnd_q;
   assign exec_lanes           = lanes_q;
   assign swizzle_sel          = sel_q;
   assign src_words            = words_q;
   assign imm_lanes            = imm_q;
   assign dst_write            = dst_q;
   assign acc_write            = acc_q;
   assign flag_write           = flg_q;
   assign instr_fault          = flt_q;

   // checks
   sequence s_handler_req;
      instr_valid && instr.except && state_q == VUOFR_RUN;
   endsequence
   chk_handler_entry: assert property (@(posedge clock) disable iff (!rst_n)
      s_handler_req |=> handler_taken && thread_instr_pointer == $past(handler_entry_pointer))
      else $error("handler entry pointer not loaded");
   chk_thread_end: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(thread_active) |-> thread_done && $past(instr.is_send && instr.end_flag))
      else $error("thread ended without end flag send");
   chk_single_flow: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == VUOFR_RUN && instr_valid && single_flow_mode && !instr.mem_operand)
      |=> exec_lanes == $past(chan_mask & width_en))
      else $error("single flow lanes wrong");
   chk_own_pointer: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == VUOFR_RUN && instr_valid && !single_flow_mode
       && channel_instr_pointer[IP_W-1:0] != ip_q) |=> !exec_lanes[0])
      else $error("lane ran with mismatched pointer");
   chk_width_lanes: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == VUOFR_RUN && instr_valid && instr.exec_width == 3'h0)
      |=> exec_lanes[CH-1:1] == '0)
      else $error("lanes beyond exec width");
   chk_mem_refused: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == VUOFR_RUN && instr_valid && instr.mem_operand)
      |=> instr_fault && exec_lanes == '0 && !dst_write)
      else $error("memory operand not refused");
   chk_null_dst: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == VUOFR_RUN && instr_valid && instr.null_dst && instr.acc_wr
       && !instr.mem_operand && (|elig)) |=> !dst_write && acc_write)
      else $error("null destination handling wrong");
   chk_unib_lane: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == VUOFR_RUN && instr_valid && instr.imm_kind == VUOFR_IMM_UNIB)
      |=> imm_lanes[15:0] == {12'h000, $past(instr.imm[3:0])})
      else $error("unsigned nibble lane zero wrong");
   chk_snib_lane: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == VUOFR_RUN && instr_valid && instr.imm_kind == VUOFR_IMM_SNIB && instr.imm[31])
      |=> imm_lanes[127:116] == 12'hFFF)
      else $error("signed nibble lane seven not extended");
   chk_native_step: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == VUOFR_RUN && instr_valid && !instr.except && !instr.is_send && !instr.compact)
      |=> thread_instr_pointer == $past(ip_q) + 32'h0000_0010)
      else $error("native step not 16 bytes");
endmodule : vuofr_core

// ==== vuofr_disp.sv ====
// thread dispatcher model that launches threads into the block
`timescale 1ns/1ns
module vuofr_disp (
   input  wire logic        go,
   input  wire logic [31:0] start_ip,
   output logic             dispatch,
   output logic [31:0]      dispatch_ip
);
   // launch strobe follows the request; the address is only valid while
   // launching, otherwise an inverted pattern so a stale sample is caught
   assign dispatch    = go;
   assign dispatch_ip = go ? start_ip : ~start_ip;
endmodule : vuofr_disp

// ==== test_vuofr_core.sv ====
// self-checking bench for the vector unit flow and operand block
`timescale 1ns/1ns
module test_vuofr_core;
   import vuofr_pkg::*;
   // expected outcome of one taken instruction
   typedef struct {
      logic [31:0]  ip;
      logic [15:0]  lanes;
      logic [63:0]  sel;
      logic [255:0] words;
      logic [127:0] imm;
      logic         chk_imm;
      logic [6:0]   flags;   // dst acc flag fault done handler active
   } vuofr_exp_t;
   logic         clock, rst_n, go, single_flow_mode, instr_valid, taken;
   logic         dispatch, thread_active, thread_done, handler_taken;
   logic         dst_write, acc_write, flag_write, instr_fault;
   logic [31:0]  start_ip, dispatch_ip, handler_entry_pointer, thread_instr_pointer, cur_ip, rnd;
   logic [15:0]  chan_mask, exec_lanes;
   logic [511:0] channel_instr_pointer;
   logic [255:0] src_data, src_words;
   logic [63:0]  swizzle_sel;
   logic [127:0] imm_lanes;
   vuofr_instr_t instr, ni;
   vuofr_exp_t   exp_q[$];
   vuofr_exp_t   me;
   int           n_mismatch = 0;
   int           comparisons = 0;
   // 10 mhz clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   vuofr_disp vuofr_disp_inst (.go(go), .start_ip(start_ip), .dispatch(dispatch),
      .dispatch_ip(dispatch_ip));
   vuofr_core vuofr_core_inst (.clock(clock), .rst_n(rst_n), .dispatch(dispatch),
      .dispatch_ip(dispatch_ip), .handler_entry_pointer(handler_entry_pointer),
      .single_flow_mode(single_flow_mode), .chan_mask(chan_mask),
      .channel_instr_pointer(channel_instr_pointer), .instr_valid(instr_valid),
      .instr(instr), .src_data(src_data), .thread_active(thread_active),
      .thread_instr_pointer(thread_instr_pointer), .thread_done(thread_done),
      .handler_taken(handler_taken), .exec_lanes(exec_lanes), .swizzle_sel(swizzle_sel),
      .src_words(src_words), .imm_lanes(imm_lanes), .dst_write(dst_write),
      .acc_write(acc_write), .flag_write(flag_write), .instr_fault(instr_fault));
   // xorshift source, fixed start
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : check
   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   // note the expectation, then present the instruction for one edge
   task automatic send_instr(input vuofr_instr_t i);
      vuofr_exp_t  e;
      logic [3:0]  s;
      logic [15:0] wm;
      logic        f;
      logic        fin;
      logic        any;
      f = i.mem_operand;
      fin = i.is_send && i.end_flag && !i.except;   // exception wins over end
      wm = (i.exec_width >= 4) ? 16'hffff : 16'((1 << (1 << i.exec_width)) - 1);
      e.imm = '0;
      for (int l = 0; l < 16; l++) begin
         s = i.quad_mode ? 4'((l / 4) * 4 + i.swizzle[2*(l%4)+:2]) : 4'(l);
         e.sel[l*4+:4] = s;
         e.words[l*16+:16] = src_data[s*16+:16];
         e.lanes[l] = !f && wm[l] && chan_mask[l] &&
            (single_flow_mode || channel_instr_pointer[l*32+:32] == cur_ip);
      end
      // lane zero in the low immediate bits
      for (int l = 0; l < 8; l++) begin
         if (i.imm_kind == VUOFR_IMM_UNIB) e.imm[l*16+:16] = {12'h000, i.imm[l*4+:4]};
         if (i.imm_kind == VUOFR_IMM_SNIB) e.imm[l*16+:16] = {{12{i.imm[l*4+3]}}, i.imm[l*4+:4]};
         if (i.imm_kind == VUOFR_IMM_RFLT && l < 4) e.imm[l*32+:32] = {24'h00_0000, i.imm[l*8+:8]};
      end
      e.chk_imm = (i.imm_kind != VUOFR_IMM_NONE);
      cur_ip = i.except ? handler_entry_pointer
                        : cur_ip + (i.compact ? 32'h0000_0008 : 32'h0000_0010);
      e.ip = cur_ip;
      // write pulses only come when at least one lane runs
      any = |e.lanes;
      e.flags = {!i.null_dst && any, i.acc_wr && any, i.flag_wr && any, f, fin, i.except, !fin};
      exp_q.push_back(e);
      instr = i;
      instr_valid = 1'b1;
      @(negedge clock);
   endtask : send_instr
   // watcher: one result a cycle after each taken instruction
   always @(posedge clock) taken <= instr_valid && thread_active;
   always @(negedge clock) begin
      if (taken === 1'b1 && exp_q.size() > 0) begin
         me = exp_q.pop_front();
         check(exec_lanes === me.lanes, "lanes");
         check({dst_write, acc_write, flag_write} === me.flags[6:4], "writes");
         check(instr_fault === me.flags[3], "fault");
         check({thread_done, handler_taken, thread_active} === me.flags[2:0],
            "flow");
         if (me.flags[0]) check(thread_instr_pointer === me.ip, "ip");
         if (!me.flags[3]) check(swizzle_sel === me.sel, "swizzle");
         if (!me.flags[3]) check(src_words === me.words, "words");
         if (me.chk_imm) check(imm_lanes === me.imm, "imm");
      end
   end
   // watchdog well beyond the few hundred cycles of the run
   initial begin
      #(100 * 5000);
      n_mismatch++;
      final_report();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      go = 1'b0;
      start_ip = 32'h0000_1000;
      handler_entry_pointer = 32'h0000_8000;
      single_flow_mode = 1'b0;
      chan_mask = '0;
      channel_instr_pointer = '0;
      instr_valid = 1'b0;
      instr = '0;
      src_data = '0;
      rnd = 32'h0000_527a;
      cur_ip = '0;
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      check({thread_active, thread_done, exec_lanes, thread_instr_pointer} === '0,
         "reset");
      go = 1'b1;
      @(negedge clock);
      go = 1'b0;
      check(thread_active === 1'b1 && thread_instr_pointer === start_ip, "start");
      cur_ip = start_ip;
      // random stream; partner also strobes dispatch while busy, which must be ignored
      for (int n = 0; n < 200; n++) begin
         rnd = xs(rnd);
         go = rnd[31];
         single_flow_mode = rnd[30];
         chan_mask = rnd[15:0];
         for (int l = 0; l < 16; l++) begin
            src_data[l*16+:16] = 16'(l * 16'h0101) ^ rnd[15:0];
            channel_instr_pointer[l*32+:32] = rnd[l+8] ? cur_ip : cur_ip + 32'h0000_0010;
         end
         rnd = xs(rnd);
         ni = '0;
         ni.ip = cur_ip;
         ni.quad_mode = rnd[0];
         ni.swizzle = rnd[8:1];
         ni.exec_width = 3'(rnd[11:9] % 5);
         ni.null_dst = rnd[12];
         ni.acc_wr = rnd[13];
         ni.flag_wr = rnd[14];
         ni.mem_operand = (rnd[17:15] == 3'b000);
         ni.compact = rnd[18];
         ni.imm_kind = vuofr_imm_kind_t'(rnd[20:19]);
         ni.imm = xs(rnd);
         send_instr(ni);
      end
      go = 1'b0;
      ni = '0;
      ni.null_dst = 1'b1;
      ni.except = 1'b1;
      send_instr(ni);
      ni.except = 1'b0;
      ni.is_send = 1'b1;
      send_instr(ni);
      ni.except = 1'b1;
      ni.end_flag = 1'b1;
      send_instr(ni);
      ni.except = 1'b0;
      send_instr(ni);
      ni.null_dst = 1'b0;
      send_instr(ni);
      instr_valid = 1'b0;
      @(negedge clock);
      check(dst_write === 1'b0 && thread_active === 1'b0, "idle instr");
      check(exp_q.size() == 1, "queue");
      final_report();
   end
endmodule : test_vuofr_core
